// >>> rtl/rofl_pkg.sv
// Purpose: Shared constants and types of the relay output function logic
// Assumes: 10 MHz system clock, 32-bit register port with byte addresses
// Notes:   Speeds are in tenths of a percent of maximum frequency
package rofl_pkg;
  // Clock and seconds tick
  localparam int CLK_HZ        = 10_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES   = TICK_PERIOD_S * CLK_HZ;
  // Field widths
  localparam int DLY_W = 10;
  localparam int SPD_W = 10;
  localparam int PV_W  = 16;
  localparam int SRC_W = 5;
  localparam int IRQ_W = 5;
  localparam int ADR_W = 8;
  // Value limits
  localparam logic [DLY_W-1:0] DLY_MAX  = 10'h258;  // 600 s
  localparam logic [SPD_W-1:0] SPD_FULL = 10'h3e8;  // 100.0 %
  localparam logic [SPD_W-1:0] SPD_HALF = 10'h1f4;  // 50.0 %, low calibration point
  // Register byte offsets
  localparam logic [ADR_W-1:0] RLY1_SRC_OFS = 8'h00;
  localparam logic [ADR_W-1:0] RLY1_ON_OFS  = 8'h04;
  localparam logic [ADR_W-1:0] RLY1_OFF_OFS = 8'h08;
  localparam logic [ADR_W-1:0] RLY2_SRC_OFS = 8'h0c;
  localparam logic [ADR_W-1:0] RLY2_ON_OFS  = 8'h10;
  localparam logic [ADR_W-1:0] RLY2_OFF_OFS = 8'h14;
  localparam logic [ADR_W-1:0] MISC_OFS     = 8'h18;
  localparam logic [ADR_W-1:0] SPEED_OFS    = 8'h1c;
  localparam logic [ADR_W-1:0] PVB_LIM_OFS  = 8'h20;
  localparam logic [ADR_W-1:0] BAND_OFS     = 8'h24;
  localparam logic [ADR_W-1:0] REG_TIME_OFS = 8'h28;
  localparam logic [ADR_W-1:0] CAL_CMD_OFS  = 8'h2c;
  localparam logic [ADR_W-1:0] CAL_PTS_OFS  = 8'h30;
  localparam logic [ADR_W-1:0] LIVE_OFS     = 8'h34;
  localparam logic [ADR_W-1:0] OUTS_OFS     = 8'h38;
  localparam logic [ADR_W-1:0] IRQ_STAT_OFS = 8'h3c;
  localparam logic [ADR_W-1:0] IRQ_MASK_OFS = 8'h40;
  // Field positions
  localparam int POL_BIT     = 8;   // Polarity bit in a source register
  localparam int ZF_SEL_LSB  = 8;   // Zero-flow input select in MISC
  localparam int HI_HALF_LSB = 16;  // Upper half of paired registers
  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // Interrupt bit positions
  localparam int IRQ_RLY1  = 0;
  localparam int IRQ_RLY2  = 1;
  localparam int IRQ_LOSTA = 2;
  localparam int IRQ_LOSTB = 3;
  localparam int IRQ_PHASE = 4;
  // Relay sources
  typedef enum logic [SRC_W-1:0] {
    SRC_OFF = 5'h00, SRC_ON = 5'h01, SRC_USER0 = 5'h02, SRC_SERIAL0 = 5'h06,
    SRC_CMP0 = 5'h0a, SRC_PVB_UNDER = 5'h0f, SRC_PVB_OVER = 5'h10, SRC_LOSTA = 5'h11,
    SRC_LOSTB = 5'h12, SRC_PHASE = 5'h13, SRC_NOFLOW = 5'h14, SRC_SYNC = 5'h15,
    SRC_SOLAR_OK = 5'h16, SRC_SOLAR_LOW = 5'h17, SRC_MPP = 5'h18, SRC_BELOW = 5'h19,
    SRC_ABOVE = 5'h1a, SRC_LOADWARN = 5'h1b
  } rofl_src_type;
  localparam int SRC_COUNT = 28;
endpackage : rofl_pkg

// >>> rtl/rofl_relay_output.sv
// Purpose: Source selection, delays and polarity for two drive relays
// Assumes: One clock, asynchronous active-low reset, plain register port
// Notes:   Alarm, digital and phase-order pin inputs are filtered by three flops before use
// Operation
// RULE1: Four latched external user alarms selectable; the code only filters the alarm pins and does not latch them
// RULE2: Four serial-written bits selectable, relay follows
// RULE3: Five comparator results selectable as sources
// RULE4: Second process below-low and above-high flags
// RULE5: Regulation lost after staying beyond band interval
// RULE6: Phase order source high for forward order
// RULE7: Zero-flow source follows selected digital input
// RULE8: Line-locked source while output synchronised
// RULE9: Solar good, low and power-search sources
// RULE10: Per-relay polarity, pass-through or flipped
// RULE11: Activation delay 0 to 600 seconds
// RULE12: De-activation delay 0 to 600 seconds
// RULE13: Below-speed source under frequency threshold
// RULE14: Above-speed source over frequency threshold
// RULE15: Two-point load curve sets warning threshold
// RULE16: Delay restarts when source returns early
// RULE17: Polarity applied after the delay stage
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Three-flop filter; a bit changes once stages two and three agree
module rofl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1Reg;  // Metastable stage, read only by s2Reg
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;
  logic [W-1:0] qReg;
  // Shift chain and agreement filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Reg <= '0;
      s2Reg <= '0;
      s3Reg <= '0;
      qReg  <= '0;
    end else begin
      s1Reg <= d;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      qReg  <= ((s2Reg ~^ s3Reg) & s3Reg) | ((s2Reg ^ s3Reg) & qReg);
    end
  end
  assign q = qReg;
endmodule : rofl_sync

// On and off delay stage counted in seconds ticks
module rofl_delay
  import rofl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             src,
  input  wire logic [DLY_W-1:0] onDelay,
  input  wire logic [DLY_W-1:0] offDelay,
  output logic                  out
);
  logic             out_reg;  // Delayed state
  logic [DLY_W-1:0] cnt_reg;  // Elapsed seconds of pending change
  wire  [DLY_W-1:0] limit = src ? onDelay : offDelay;
  wire              done  = (cnt_reg >= limit);
  // Count while source differs from output, else restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (src == out_reg) begin
      cnt_reg <= '0;  // see RULE16
    end else if (done) begin
      out_reg <= src;  // see RULE11 see RULE12
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  assign out = out_reg;
endmodule : rofl_delay

module rofl_relay_output
  import rofl_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES  // Cycles per seconds tick
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [ADR_W-1:0] addr,
  input  wire logic [31:0]      wrData,
  input  wire logic             wrStb,
  input  wire logic             rdStb,
  output logic      [31:0]      rdData,
  input  wire logic [3:0]       userAlarm,
  input  wire logic [7:0]       digitalIn,
  input  wire logic             phaseOrderForward,
  input  wire logic [4:0]       comparatorResult,
  input  wire logic [PV_W-1:0]  secondProcess,
  input  wire logic [PV_W-1:0]  firstProcessError,
  input  wire logic [PV_W-1:0]  secondProcessError,
  input  wire logic             lineSynchronised,
  input  wire logic             solarSufficient,
  input  wire logic             powerPointSearchActive,
  input  wire logic [SPD_W-1:0] motorFreq,
  input  wire logic [PV_W-1:0]  motorLoad,
  output logic      [1:0]       relayDrive,
  output logic                  irq
);
  // Configuration registers
  logic [SRC_W-1:0] rly1Sel_reg, rly2Sel_reg;     // Source selectors
  logic             relay_one_polarity_reg;       // Flip relay one
  logic             relay_two_polarity_reg;       // Flip relay two
  logic [DLY_W-1:0] rly1On_reg, rly1Off_reg;      // Relay one delays
  logic [DLY_W-1:0] relay_two_on_delay_reg;       // Relay two on delay
  logic [DLY_W-1:0] rly2Off_reg;                  // Relay two off delay
  logic [3:0]       serial_written_bit_reg;       // Bits set by serial commands
  logic [2:0]       zeroFlowSel_reg;              // Digital input for zero flow
  logic [SPD_W-1:0] below_speed_threshold_reg;
  logic [SPD_W-1:0] above_speed_threshold_reg;
  logic [PV_W-1:0]  process_low_limit_reg, process_high_limit_reg;
  logic [PV_W-1:0]  bandA_reg, bandB_reg;         // Regulation band limits
  logic [DLY_W-1:0] intervalA_reg, intervalB_reg; // Regulation loss intervals
  logic [PV_W-1:0]  calLow_reg, calHigh_reg;      // Load curve points
  logic             calLowOk_reg, calHighOk_reg;  // Points captured
  logic [IRQ_W-1:0] irqStat_reg, irqMask_reg;
  logic [31:0]      rdData_reg;
  logic [31:0]      rdData_next;
  // Seconds tick and edge history
  logic [31:0]      tickCnt_reg;
  logic             tick_reg;
  logic [1:0]       drivePrev_reg;
  logic             lostAPrev_reg, lostBPrev_reg, phasePrev_reg;

  // Synchronised pins
  logic [3:0] alarmSync;
  logic [7:0] dinSync;
  logic       phaseSync;
  rofl_sync #(.W(13)) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .d    ({phaseOrderForward, digitalIn, userAlarm}),
    .q    ({phaseSync, dinSync, alarmSync})
  );

  // Seconds tick from the system clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_reg <= '0;
      tick_reg    <= 1'b0;
    end else if (tickCnt_reg == 32'(TICK_LEN - 1)) begin
      tickCnt_reg <= '0;
      tick_reg    <= 1'b1;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h1;
      tick_reg    <= 1'b0;
    end
  end

  // Process comparisons
  wire pvbUnder = (secondProcess < process_low_limit_reg);   // see RULE4
  wire pvbOver  = (secondProcess > process_high_limit_reg);  // see RULE4
  wire beyondA  = (firstProcessError > bandA_reg);
  wire beyondB  = (secondProcessError > bandB_reg);
  logic lostA, lostB;
  // Regulation loss reuses the delay stage with no release delay
  rofl_delay u_lostA (
    .clk(clk), .rst_n(rst_n), .tick(tick_reg), .src(beyondA),
    .onDelay(intervalA_reg), .offDelay('0), .out(lostA)  // see RULE5
  );
  rofl_delay u_lostB (
    .clk(clk), .rst_n(rst_n), .tick(tick_reg), .src(beyondB),
    .onDelay(intervalB_reg), .offDelay('0), .out(lostB)  // see RULE5
  );

  // Load curve: flat below half speed, straight line to full speed
  wire [SPD_W-1:0]   fAbove  = (motorFreq > SPD_HALF) ? (motorFreq - SPD_HALF) : '0;
  wire signed [17:0] calDiff = $signed({2'b00, calHigh_reg}) - $signed({2'b00, calLow_reg});
  wire signed [28:0] calProd = calDiff * $signed({1'b0, fAbove});
  wire signed [28:0] calStep = calProd / $signed({19'h0, SPD_HALF});
  wire signed [18:0] loadTh  = $signed({3'b000, calLow_reg}) + calStep[18:0];
  wire loadWarn = calLowOk_reg && calHighOk_reg &&
                  ($signed({3'b000, motorLoad}) > loadTh);  // see RULE15

  // Source vector indexed by the source enumeration
  wire [SRC_COUNT-1:0] srcVec = {
    loadWarn,                                   // see RULE15
    (motorFreq > above_speed_threshold_reg),    // see RULE14
    (motorFreq < below_speed_threshold_reg),    // see RULE13
    powerPointSearchActive,                     // see RULE9
    ~solarSufficient,                           // see RULE9
    solarSufficient,                            // see RULE9
    lineSynchronised,                           // see RULE8
    dinSync[zeroFlowSel_reg],                   // see RULE7
    phaseSync,                                  // see RULE6
    lostB, lostA,                               // see RULE5
    pvbOver, pvbUnder,
    comparatorResult,                           // see RULE3
    serial_written_bit_reg,                     // see RULE2
    alarmSync,                                  // see RULE1
    1'b1, 1'b0
  };
  // Codes past the last source read as inactive
  wire rly1Src = (rly1Sel_reg < SRC_W'(SRC_COUNT)) ? srcVec[rly1Sel_reg] : 1'b0;
  wire rly2Src = (rly2Sel_reg < SRC_W'(SRC_COUNT)) ? srcVec[rly2Sel_reg] : 1'b0;

  // Delay stages act on the source itself
  logic rly1Dly, rly2Dly;
  rofl_delay u_rly1 (
    .clk(clk), .rst_n(rst_n), .tick(tick_reg), .src(rly1Src),
    .onDelay(rly1On_reg), .offDelay(rly1Off_reg), .out(rly1Dly)
  );
  rofl_delay u_rly2 (
    .clk(clk), .rst_n(rst_n), .tick(tick_reg), .src(rly2Src),
    .onDelay(relay_two_on_delay_reg), .offDelay(rly2Off_reg), .out(rly2Dly)
  );
  // Polarity after the delay so delays keep the source edge
  assign relayDrive = {rly2Dly ^ relay_two_polarity_reg,
                       rly1Dly ^ relay_one_polarity_reg};  // see RULE10 see RULE17

  // Write decode
  wire hitR1Src = wrStb && (addr == RLY1_SRC_OFS);
  wire hitR1On  = wrStb && (addr == RLY1_ON_OFS);
  wire hitR1Off = wrStb && (addr == RLY1_OFF_OFS);
  wire hitR2Src = wrStb && (addr == RLY2_SRC_OFS);
  wire hitR2On  = wrStb && (addr == RLY2_ON_OFS);
  wire hitR2Off = wrStb && (addr == RLY2_OFF_OFS);
  wire hitMisc  = wrStb && (addr == MISC_OFS);
  wire hitSpeed = wrStb && (addr == SPEED_OFS);
  wire hitPvb   = wrStb && (addr == PVB_LIM_OFS);
  wire hitBand  = wrStb && (addr == BAND_OFS);
  wire hitTime  = wrStb && (addr == REG_TIME_OFS);
  wire hitCal   = wrStb && (addr == CAL_CMD_OFS);
  wire hitStat  = wrStb && (addr == IRQ_STAT_OFS);
  wire hitMask  = wrStb && (addr == IRQ_MASK_OFS);
  // Delays above 600 s are held at 600 s
  wire [DLY_W-1:0] dlyLo = (wrData[DLY_W-1:0] > DLY_MAX) ? DLY_MAX : wrData[DLY_W-1:0];
  wire [DLY_W-1:0] dlyHi = (wrData[HI_HALF_LSB +: DLY_W] > DLY_MAX) ? DLY_MAX
                         : wrData[HI_HALF_LSB +: DLY_W];
  // Speeds above 100.0 % are held at 100.0 %
  wire [SPD_W-1:0] spdLo = (wrData[SPD_W-1:0] > SPD_FULL) ? SPD_FULL : wrData[SPD_W-1:0];
  wire [SPD_W-1:0] spdHi = (wrData[HI_HALF_LSB +: SPD_W] > SPD_FULL) ? SPD_FULL
                         : wrData[HI_HALF_LSB +: SPD_W];

  // Relay configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rly1Sel_reg <= SRC_OFF;
      rly2Sel_reg <= SRC_OFF;
      relay_one_polarity_reg <= 1'b0;
      relay_two_polarity_reg <= 1'b0;
      rly1On_reg  <= '0;
      rly1Off_reg <= '0;
      relay_two_on_delay_reg <= '0;
      rly2Off_reg <= '0;
    end else begin
      if (hitR1Src) begin
        rly1Sel_reg <= wrData[SRC_W-1:0];
        relay_one_polarity_reg <= wrData[POL_BIT];  // see RULE10
      end
      if (hitR2Src) begin
        rly2Sel_reg <= wrData[SRC_W-1:0];
        relay_two_polarity_reg <= wrData[POL_BIT];  // see RULE10
      end
      if (hitR1On)  rly1On_reg  <= dlyLo;              // see RULE11
      if (hitR1Off) rly1Off_reg <= dlyLo;              // see RULE12
      if (hitR2On)  relay_two_on_delay_reg <= dlyLo;   // see RULE11
      if (hitR2Off) rly2Off_reg <= dlyLo;              // see RULE12
    end
  end

  // Function parameter registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_written_bit_reg    <= '0;
      zeroFlowSel_reg           <= '0;
      below_speed_threshold_reg <= '0;
      above_speed_threshold_reg <= '0;
      process_low_limit_reg     <= '0;
      process_high_limit_reg    <= '0;
      bandA_reg                 <= '0;
      bandB_reg                 <= '0;
      intervalA_reg             <= '0;
      intervalB_reg             <= '0;
    end else begin
      if (hitMisc) begin
        serial_written_bit_reg <= wrData[3:0];                // see RULE2
        zeroFlowSel_reg        <= wrData[ZF_SEL_LSB +: 3];    // see RULE7
      end
      if (hitSpeed) begin
        below_speed_threshold_reg <= spdLo;  // see RULE13
        above_speed_threshold_reg <= spdHi;  // see RULE14
      end
      if (hitPvb) begin
        process_low_limit_reg  <= wrData[PV_W-1:0];
        process_high_limit_reg <= wrData[HI_HALF_LSB +: PV_W];
      end
      if (hitBand) begin
        bandA_reg <= wrData[PV_W-1:0];
        bandB_reg <= wrData[HI_HALF_LSB +: PV_W];
      end
      if (hitTime) begin
        intervalA_reg <= dlyLo;
        intervalB_reg <= dlyHi;
      end
    end
  end

  // Load curve capture; the operator runs the drive at each point first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calLow_reg    <= '0;
      calHigh_reg   <= '0;
      calLowOk_reg  <= 1'b0;
      calHighOk_reg <= 1'b0;
    end else if (hitCal) begin
      if (wrData[0]) begin
        calLow_reg   <= motorLoad;  // see RULE15
        calLowOk_reg <= 1'b1;
      end
      if (wrData[1]) begin
        calHigh_reg   <= motorLoad;  // see RULE15
        calHighOk_reg <= 1'b1;
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  wire [IRQ_W-1:0] irqEvt = {
    (phaseSync != phasePrev_reg),
    (lostB && !lostBPrev_reg),
    (lostA && !lostAPrev_reg),
    (relayDrive[1] != drivePrev_reg[1]),
    (relayDrive[0] != drivePrev_reg[0])
  };
  wire [IRQ_W-1:0] irqClr = hitStat ? wrData[IRQ_W-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_reg   <= '0;
      irqMask_reg   <= '0;
      drivePrev_reg <= '0;
      lostAPrev_reg <= 1'b0;
      lostBPrev_reg <= 1'b0;
      phasePrev_reg <= 1'b0;
    end else begin
      irqStat_reg   <= (irqStat_reg & ~irqClr) | irqEvt;
      drivePrev_reg <= relayDrive;
      lostAPrev_reg <= lostA;
      lostBPrev_reg <= lostB;
      phasePrev_reg <= phaseSync;
      if (hitMask) irqMask_reg <= wrData[IRQ_W-1:0];
    end
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  // Read decode; unmapped offsets read zero
  always_comb begin
    rdData_next = REG_RST;
    if (addr == RLY1_SRC_OFS)      rdData_next = {23'h0, relay_one_polarity_reg, 3'h0, rly1Sel_reg};
    else if (addr == RLY1_ON_OFS)  rdData_next = {22'h0, rly1On_reg};
    else if (addr == RLY1_OFF_OFS) rdData_next = {22'h0, rly1Off_reg};
    else if (addr == RLY2_SRC_OFS) rdData_next = {23'h0, relay_two_polarity_reg, 3'h0, rly2Sel_reg};
    else if (addr == RLY2_ON_OFS)  rdData_next = {22'h0, relay_two_on_delay_reg};
    else if (addr == RLY2_OFF_OFS) rdData_next = {22'h0, rly2Off_reg};
    else if (addr == MISC_OFS)     rdData_next = {21'h0, zeroFlowSel_reg, 4'h0, serial_written_bit_reg};
    else if (addr == SPEED_OFS)    rdData_next = {6'h0, above_speed_threshold_reg, 6'h0, below_speed_threshold_reg};
    else if (addr == PVB_LIM_OFS)  rdData_next = {process_high_limit_reg, process_low_limit_reg};
    else if (addr == BAND_OFS)     rdData_next = {bandB_reg, bandA_reg};
    else if (addr == REG_TIME_OFS) rdData_next = {6'h0, intervalB_reg, 6'h0, intervalA_reg};
    else if (addr == CAL_CMD_OFS)  rdData_next = {30'h0, calHighOk_reg, calLowOk_reg};
    else if (addr == CAL_PTS_OFS)  rdData_next = {calHigh_reg, calLow_reg};
    else if (addr == LIVE_OFS)     rdData_next = {4'h0, srcVec};
    else if (addr == OUTS_OFS)     rdData_next = {28'h0, relayDrive, rly2Dly, rly1Dly};
    else if (addr == IRQ_STAT_OFS) rdData_next = {27'h0, irqStat_reg};
    else if (addr == IRQ_MASK_OFS) rdData_next = {27'h0, irqMask_reg};
  end
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdData_reg <= '0;
    else        rdData_reg <= rdStb ? rdData_next : '0;
  end
  assign rdData = rdData_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_select;
    (rly2Sel_reg == SRC_USER0) |-> (rly2Src == alarmSync[0]);
  endproperty
  a_select: assert property (p_select) else $error("user alarm not routed");  // see RULE1
  property p_serial;
    hitMisc |=> (srcVec[SRC_SERIAL0 +: 4] == $past(wrData[3:0]));
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit not followed");  // see RULE2
  property p_cmp;
    (rly2Sel_reg == SRC_CMP0 + 5'h4) |-> (rly2Src == comparatorResult[4]);
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator five not routed");  // see RULE3
  property p_pvb;
    (process_low_limit_reg <= process_high_limit_reg) |-> !(srcVec[SRC_PVB_UNDER] && srcVec[SRC_PVB_OVER]);
  endproperty
  a_pvb: assert property (p_pvb) else $error("limit flags inconsistent");  // see RULE4
  property p_lost;
    lostA |-> $past(beyondA);
  endproperty
  a_lost: assert property (p_lost) else $error("regulation lost while in band");  // see RULE5
  property p_phase;
    $changed(phaseSync) |=> irqStat_reg[IRQ_PHASE];
  endproperty
  a_phase: assert property (p_phase) else $error("phase change not flagged");  // see RULE6
  property p_zero_on;
    (rly1Src && !rly1Dly && rly1On_reg == 10'h000) |=> rly1Dly;
  endproperty
  a_zero_on: assert property (p_zero_on) else $error("zero on delay not immediate");  // see RULE11
  property p_zero_off;
    (!rly1Src && rly1Dly && rly1Off_reg == 10'h000) |=> !rly1Dly;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero off delay not immediate");  // see RULE12
  property p_hold;
    (rly1Src == rly1Dly) |=> $stable(rly1Dly);
  endproperty
  a_hold: assert property (p_hold) else $error("relay moved without cause");  // see RULE16
  property p_polarity;
    $changed(relay_one_polarity_reg) && $stable(rly1Dly) |-> $changed(relayDrive[0]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");  // see RULE17
  property p_below;
    (rly1Sel_reg == SRC_BELOW && motorFreq < below_speed_threshold_reg && rly1On_reg == 10'h000)
      |=> rly1Dly;
  endproperty
  a_below: assert property (p_below) else $error("below speed relay idle");  // see RULE13
  property p_read_idle;
    !rdStb |=> (rdData == 32'h0000_0000);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside its cycle");

  c_rly1_on:  cover property ($rose(relayDrive[0]));
  c_lost:     cover property ($rose(lostA));
  c_irq:      cover property ($rose(irq));
  c_loadwarn: cover property ($rose(loadWarn));
endmodule : rofl_relay_output

`default_nettype wire

// >>> tb/rofl_contact_model.sv
// Purpose: Relay contact set beyond the coil drives
// Assumes: Contacts follow the coil two clocks late
// Notes:   Bounce is not modelled, only armature travel
`timescale 1ns/1ps
`default_nettype none
module rofl_contact_model (
  input  wire logic       clk,
  input  wire logic [1:0] coil,
  output logic      [1:0] closed
);
  logic [1:0] armReg;  // Armature half way
  // Contacts lag the coil by the armature travel
  always_ff @(posedge clk) begin
    armReg <= coil;
    closed <= armReg;
  end
endmodule : rofl_contact_model
`default_nettype wire

// >>> tb/rofl_relay_output_test.sv
// Purpose: Register-driven checks of relay sources, delays and polarity
// Assumes: Seconds tick shortened to 4 clocks
// Notes:   Alarm, digital and phase-order pins pass a three-flop filter, so waits allow for it
`timescale 1ns/1ps
`default_nettype none
module rofl_relay_output_test
  import rofl_pkg::*;
;
  logic             clk = 1'b0, rst_n = 1'b0, wrStb = 1'b0, rdStb = 1'b0;
  logic             ph = 1'b0, sync = 1'b0, solar = 1'b0, mpp = 1'b0, irq;
  logic [ADR_W-1:0] addr = 8'h00;
  logic [31:0]      wrData = 32'h0, rdData;
  logic [PV_W-1:0]  pvB = 16'h0, errA = 16'h0, errB = 16'h0, load = 16'h0;
  logic [SPD_W-1:0] freq = 10'h0;
  logic [7:0]       din = 8'h0;
  logic [4:0]       cmp = 5'h0;
  logic [3:0]       alarm = 4'h0;
  logic [1:0]       drive, closed;
  logic [2:0]       outs;  // Watched outputs in one vector
  int               errTotal = 0, cmpCount = 0;
  assign outs = {irq, drive};
  rofl_relay_output #(.TICK_LEN(4)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .userAlarm(alarm), .digitalIn(din),
    .phaseOrderForward(ph), .comparatorResult(cmp), .secondProcess(pvB), .firstProcessError(errA),
    .secondProcessError(errB), .lineSynchronised(sync), .solarSufficient(solar),
    .powerPointSearchActive(mpp), .motorFreq(freq), .motorLoad(load), .relayDrive(drive), .irq(irq));
  rofl_contact_model contacts (.clk(clk), .coil(drive), .closed(closed));
  // Free-running 100 ns clock
  always #50 clk = ~clk;
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One-cycle write strobe
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(string name, logic [7:0] a, logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 check(name, exp, rdData);
  endtask : rd
  // Bounded wait on one watched output
  task automatic waitBit(string name, int i, logic v, int n);
    for (int k = 0; k < n && outs[i] !== v; k++) @(posedge clk) #1;
    check(name, {31'h0, v}, {31'h0, outs[i]});
  endtask : waitBit
  task automatic printVerdict();
    if (errTotal == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : printVerdict
  // Hang guard, far beyond the hundred-odd clocks needed
  initial begin
    #300000;
    errTotal++;
    printVerdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd("outs", OUTS_OFS, 32'h0);
    rd("unmapped", 8'h44, 32'h0);
    wr(RLY1_SRC_OFS, 32'h1);
    waitBit("rly1 on", 0, 1'b1, 3);
    rd("outs on", OUTS_OFS, 32'h5);
    check("contacts", 32'h1, {31'h0, closed[0]});
    wr(RLY1_SRC_OFS, 32'h101);
    #1 check("rly1 flip", 32'h0, {30'h0, drive});
    // Relay two on a user alarm with both delays
    wr(RLY2_ON_OFS, 32'h3);
    wr(RLY2_OFF_OFS, 32'h2);
    wr(RLY2_SRC_OFS, 32'h2);
    alarm <= 4'h1;
    repeat (10) @(posedge clk) #1;
    check("on early", 32'h0, {31'h0, drive[1]});
    waitBit("on late", 1, 1'b1, 10);
    // Short drops must restart the release count
    repeat (3) begin
      alarm <= 4'h0;
      repeat (3) @(posedge clk);
      alarm <= 4'h1;
      repeat (5) @(posedge clk);
    end
    #1 check("restart", 32'h1, {31'h0, drive[1]});
    alarm <= 4'h0;
    repeat (6) @(posedge clk) #1;
    check("off early", 32'h1, {31'h0, drive[1]});
    waitBit("off late", 1, 1'b0, 10);
    // Regulation loss raises a masked-in interrupt
    wr(IRQ_STAT_OFS, 32'h1f);
    wr(IRQ_MASK_OFS, 32'h4);
    wr(BAND_OFS, 32'ha);
    wr(REG_TIME_OFS, 32'h2);
    errA <= 16'h14;
    repeat (3) @(posedge clk) #1;
    check("lost early", 32'h0, {31'h0, irq});
    waitBit("lost irq", 2, 1'b1, 12);
    rd("irq stat", IRQ_STAT_OFS, 32'h4);
    wr(IRQ_MASK_OFS, 32'h0);
    #1 check("masked", 32'h0, {31'h0, irq});
    wr(IRQ_STAT_OFS, 32'h4);
    wr(IRQ_MASK_OFS, 32'h4);
    #1 check("cleared", 32'h0, {31'h0, irq});
    // Live source vector for two pin patterns
    errA <= 16'h0;
    wr(MISC_OFS, 32'h30a);
    wr(SPEED_OFS, 32'h02bc012c);
    wr(PVB_LIM_OFS, 32'h00c80064);
    wr(RLY1_SRC_OFS, 32'h19);
    wr(RLY2_SRC_OFS, 32'he);
    {alarm, cmp, pvB, ph, din, sync, solar, mpp, freq} <= {4'h5, 5'h13, 16'h32, 1'b1, 8'h8, 3'h6, 10'hc8};
    repeat (8) @(posedge clk);
    rd("live a", LIVE_OFS, 32'h0278ce96);
    check("below a", 32'h1, {31'h0, drive[0]});
    {alarm, cmp, pvB, ph, din, sync, solar, mpp, freq} <= {4'ha, 5'hc, 16'hfa, 1'b0, 8'h0, 3'h1, 10'h384};
    repeat (8) @(posedge clk);
    rd("live b", LIVE_OFS, 32'h058132aa);
    check("below b", 32'h0, {31'h0, drive[0]});
    // Load curve: capture at half and full speed, then run between them
    {freq, load} <= {10'h1f4, 16'h64};
    wr(CAL_CMD_OFS, 32'h1);
    {freq, load} <= {10'h3e8, 16'h12c};
    wr(CAL_CMD_OFS, 32'h2);
    {freq, load} <= {10'h2ee, 16'hc9};
    rd("cal pts", CAL_PTS_OFS, 32'h012c0064);
    rd("warn", LIVE_OFS, 32'h0d8132aa);
    printVerdict();
  end
endmodule : rofl_relay_output_test
`default_nettype wire
